// file: nand_seq.sv
// Notes on behaviour
// RULE1: 10h, 8 dummy, page commits buffer
// RULE2: buffer 2112 bytes; ECC programs 2048
// RULE3: busy high through self-timed program
// RULE4: program completion clears write latch
// RULE5: protected page program is ignored
// RULE6: host programs a page four times max
// RULE7: host programs pages in ascending order
// RULE8: 13h, 8 dummy, page loads buffer
// RULE9: busy high until buffer is loaded
// RULE10: status answered; other commands wait busy (no status opcode here; every opcode is dropped while busy)
// RULE11: buffer-mode bit selects read mode
// RULE12: 03h then 24 address/dummy bits
// RULE13: 0Bh then 24 or 32 bits
// RULE14: 0Ch column then 24/40 dummy
// RULE15: MSB first on falling edge, increment
// RULE16: chip select rise ends read
// RULE17: buffer mode stops at end, hi-z
// RULE18: continuous mode runs across pages
// RULE19: 3Bh drives two data lines
// RULE20: host sets write latch before loading
// RULE21: input bits MSB first while selected
`timescale 1ns/100ps
`default_nettype none
module nand_seq #(
  parameter int NUM_PAGES = 64,
  parameter int PROG_CYCLES = nsq_pkg::PROG_CYC,
  parameter int FETCH_CYCLES = nsq_pkg::FETCH_CYC
) (
  // core side
  input wire logic core_clk,
  input wire logic rst_b,
  // configuration and status
  input wire logic buffer_mode,
  input wire logic ecc_enable,
  input wire logic top_bottom_select,
  input wire logic protect_range_bit2,
  input wire logic protect_range_bit1,
  input wire logic protect_range_bit0,
  input wire logic wel_set,
  output logic write_latch_flag,
  output logic busy,
  // serial link
  input wire logic sck,
  input wire logic cs_b,
  input wire logic data_line_zero_in,
  output logic data_line_zero_out,
  output logic data_line_zero_oe_b,
  input wire logic data_line_one_in,
  output logic data_line_one_out,
  output logic data_line_one_oe_b
);
  import nsq_pkg::*;

  initial begin
    if (NUM_PAGES < 1 || (NUM_PAGES & (NUM_PAGES - 1)) != 0)
      $error("NUM_PAGES must be a power of two");
    if (PROG_CYCLES <= BUF_BYTES || FETCH_CYCLES <= BUF_BYTES)
      $error("cycle counts must exceed the buffer copy");
    if (PROG_CYCLES >= 2 ** TMR_W || FETCH_CYCLES >= 2 ** TMR_W)
      $error("cycle counts too large for timer");
  end

  logic [7:0] buf_mem [BUF_BYTES];
  logic [7:0] arr_mem [NUM_PAGES * BUF_BYTES];

  function automatic int arr_idx(input logic [PAGE_W-1:0] pg, input logic [COL_W-1:0] col);
    arr_idx = (int'(pg) % NUM_PAGES) * BUF_BYTES + int'(col);
  endfunction

  function automatic logic is_prot(input logic [PAGE_W-1:0] pg, input logic tb,
                                   input logic [2:0] bp);
    int span;
    int p;
    span = NUM_PAGES >> (7 - int'(bp));
    p = int'(pg) % NUM_PAGES;
    if (bp == 3'h0)
      is_prot = 1'b0;
    else if (tb)
      is_prot = p < span;
    else
      is_prot = p >= NUM_PAGES - span;
  endfunction

  function automatic logic is_rd(input logic [7:0] op);
    is_rd = op == OP_READ || op == OP_FAST || op == OP_FAST4 || op == OP_DUAL;
  endfunction

  function automatic logic [6:0] rd_end(input logic [7:0] op, input logic bm);
    if (op == OP_READ)
      rd_end = END_READ;
    else if (op == OP_FAST4)
      rd_end = bm ? END_FAST4_BUF : END_FAST4_CONT;
    else
      rd_end = bm ? END_FAST_BUF : END_FAST_CONT;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link side: command shift-in on rising sck
  logic [6:0] cnt_q, cnt_d;
  logic [15:0] sr_q, sr_d;
  logic [7:0] op_q, op_d;
  logic [COL_W-1:0] col_q, col_d;
  logic don_q, don_d;
  logic bsy_m_q, bsy_s_q, bm_m_q, bm_s_q;
  logic tg_q, tg_d, xop_q, xop_d;
  logic [PAGE_W-1:0] xpg_q, xpg_d;

  always_comb begin
    cnt_d = cnt_q;
    sr_d = {sr_q[14:0], data_line_zero_in}; // [RULE21]
    op_d = op_q;
    col_d = col_q;
    don_d = don_q;
    tg_d = tg_q;
    xop_d = xop_q;
    xpg_d = xpg_q;
    if (cnt_q != CNT_MAX)
      cnt_d = cnt_q + 7'h01;
    if (cnt_q == OPC_LAST)
      op_d = bsy_s_q ? OP_NONE : sr_d[7:0]; // [RULE10]
    if (cnt_q == COL_LAST && is_rd(op_q))
      col_d = sr_d[COL_W-1:0];
    if (cnt_q == HDR_LAST && (op_q == OP_PROG || op_q == OP_FETCH)) begin // [RULE1] [RULE8]
      tg_d = ~tg_q;
      xop_d = op_q == OP_PROG;
      xpg_d = sr_d;
    end
    if (is_rd(op_q) && cnt_q == rd_end(op_q, bm_s_q) - 7'h01) // [RULE12] [RULE13] [RULE14]
      don_d = 1'b1;
  end

  // frame state clears whenever chip select is high
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      cnt_q <= 7'h00;
      sr_q <= 16'h0000;
      op_q <= OP_NONE;
      col_q <= '0;
      don_q <= 1'b0;
      bsy_m_q <= 1'b1;
      bsy_s_q <= 1'b1;
      bm_m_q <= 1'b0;
      bm_s_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      op_q <= op_d;
      col_q <= col_d;
      don_q <= don_d;
      bsy_m_q <= busy;
      bsy_s_q <= bsy_m_q;
      bm_m_q <= buffer_mode;
      bm_s_q <= bm_m_q;
    end
  end

  // command handed to the core outlives the frame
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      tg_q <= 1'b0;
      xop_q <= 1'b0;
      xpg_q <= '0;
    end else begin
      tg_q <= tg_d;
      xop_q <= xop_d;
      xpg_q <= xpg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link side: data shift-out on falling sck
  logic [COL_W-1:0] pcol_q, pcol_d, ccol;
  logic [PAGE_W-1:0] ppg_q, ppg_d, cpg, fpg_q;
  logic far_q, far_d, cfar, stt_q, stt_d, dne_q, dne_d;
  logic [2:0] obit_q, obit_d;
  logic [7:0] osh_q, osh_d, byte_v;
  logic o0_d, o1_d, e0_d, e1_d, dual;

  always_comb begin
    pcol_d = pcol_q;
    ppg_d = ppg_q;
    far_d = far_q;
    stt_d = stt_q;
    dne_d = dne_q;
    obit_d = obit_q;
    osh_d = osh_q;
    o0_d = data_line_zero_out;
    o1_d = data_line_one_out;
    e0_d = data_line_zero_oe_b;
    e1_d = data_line_one_oe_b;
    dual = op_q == OP_DUAL;
    ccol = stt_q ? pcol_q : (bm_s_q ? col_q : '0); // [RULE11] [RULE18]
    cpg = stt_q ? ppg_q : fpg_q;
    cfar = stt_q & far_q;
    byte_v = cfar ? arr_mem[arr_idx(cpg, ccol)] : buf_mem[ccol];
    if (don_q && !dne_q) begin
      if (obit_q == 3'h0) begin
        stt_d = 1'b1;
        if (bm_s_q && int'(ccol) >= BUF_BYTES) begin // [RULE17]
          dne_d = 1'b1;
          e0_d = 1'b1;
          e1_d = 1'b1;
        end else begin
          o1_d = byte_v[7]; // [RULE15]
          e1_d = 1'b0;
          if (dual) begin // [RULE19]
            o0_d = byte_v[6];
            e0_d = 1'b0;
            osh_d = {byte_v[5:0], 2'b00};
            obit_d = 3'h3;
          end else begin
            osh_d = {byte_v[6:0], 1'b0};
            obit_d = 3'h7;
          end
          pcol_d = ccol + 12'h001;
          ppg_d = cpg;
          far_d = cfar;
          if (!bm_s_q && int'(ccol) == BUF_BYTES - 1) begin // [RULE18]
            pcol_d = '0;
            ppg_d = cpg + 16'h0001;
            far_d = 1'b1;
          end
        end
      end else begin
        o1_d = osh_q[7];
        obit_d = obit_q - 3'h1;
        if (dual) begin
          o0_d = osh_q[6];
          osh_d = {osh_q[5:0], 2'b00};
        end else
          osh_d = {osh_q[6:0], 1'b0};
      end
    end
  end

  // chip select rise ends the read and releases both lines
  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin // [RULE16]
      pcol_q <= '0;
      ppg_q <= '0;
      far_q <= 1'b0;
      stt_q <= 1'b0;
      dne_q <= 1'b0;
      obit_q <= 3'h0;
      osh_q <= 8'h00;
      data_line_zero_out <= 1'b0;
      data_line_one_out <= 1'b0;
      data_line_zero_oe_b <= 1'b1;
      data_line_one_oe_b <= 1'b1;
    end else begin
      pcol_q <= pcol_d;
      ppg_q <= ppg_d;
      far_q <= far_d;
      stt_q <= stt_d;
      dne_q <= dne_d;
      obit_q <= obit_d;
      osh_q <= osh_d;
      data_line_zero_out <= o0_d;
      data_line_one_out <= o1_d;
      data_line_zero_oe_b <= e0_d;
      data_line_one_oe_b <= e1_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core side: self-timed program and fetch
  core_state_t st_q, st_d;
  logic cs_m_q, cs_s_q, et_m_q, et_s_q, et_d_q, pend_q, pend_d;
  logic busy_d, wel_d, aw, bw, prot, exec_edge;
  logic [PAGE_W-1:0] pg_q, pg_d, fpg_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [COL_W-1:0] idx_q, idx_d;
  logic [12:0] lim;

  always_comb begin
    st_d = st_q;
    pend_d = pend_q;
    busy_d = busy;
    wel_d = write_latch_flag;
    pg_d = pg_q;
    fpg_d = fpg_q;
    tmr_d = tmr_q;
    idx_d = idx_q;
    aw = 1'b0;
    bw = 1'b0;
    exec_edge = et_s_q ^ et_d_q;
    prot = is_prot(xpg_q, top_bottom_select,
                   {protect_range_bit2, protect_range_bit1, protect_range_bit0});
    lim = ecc_enable ? 13'(USER_BYTES) : 13'(BUF_BYTES); // [RULE2]
    case (st_q)
      S_IDLE: begin
        if (pend_q && cs_s_q) begin // [RULE3] [RULE9]
          pend_d = 1'b0;
          pg_d = xpg_q;
          idx_d = '0;
          if (xop_q && !prot) begin // [RULE5]
            st_d = S_PROG;
            busy_d = 1'b1;
            tmr_d = TMR_W'(PROG_CYCLES - 1);
          end else if (!xop_q) begin
            st_d = S_FETCH;
            busy_d = 1'b1;
            fpg_d = xpg_q;
            tmr_d = TMR_W'(FETCH_CYCLES - 1);
          end
        end
      end
      S_PROG: begin
        if ({1'b0, idx_q} < lim) begin // [RULE1]
          aw = 1'b1;
          idx_d = idx_q + 12'h001;
        end
        tmr_d = tmr_q - 1'b1;
        if (tmr_q == '0) begin
          st_d = S_IDLE;
          busy_d = 1'b0; // [RULE3]
          wel_d = 1'b0; // [RULE4]
        end
      end
      S_FETCH: begin
        if (int'(idx_q) < BUF_BYTES) begin // [RULE8]
          bw = 1'b1;
          idx_d = idx_q + 12'h001;
        end
        tmr_d = tmr_q - 1'b1;
        if (tmr_q == '0) begin
          st_d = S_IDLE;
          busy_d = 1'b0; // [RULE9]
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (exec_edge)
      pend_d = 1'b1;
    if (wel_set)
      wel_d = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      pend_q <= 1'b0;
      busy <= 1'b0;
      write_latch_flag <= 1'b0;
      pg_q <= '0;
      fpg_q <= '0;
      tmr_q <= '0;
      idx_q <= '0;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      et_m_q <= 1'b0;
      et_s_q <= 1'b0;
      et_d_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pend_q <= pend_d;
      busy <= busy_d;
      write_latch_flag <= wel_d;
      pg_q <= pg_d;
      fpg_q <= fpg_d;
      tmr_q <= tmr_d;
      idx_q <= idx_d;
      cs_m_q <= cs_b;
      cs_s_q <= cs_m_q;
      et_m_q <= tg_q;
      et_s_q <= et_m_q;
      et_d_q <= et_s_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (aw)
      arr_mem[arr_idx(pg_q, idx_q)] <= buf_mem[idx_q];
    if (bw)
      buf_mem[idx_q] <= arr_mem[arr_idx(pg_q, idx_q)];
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_prog_busy: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE3]
    $rose(st_q == S_PROG) |-> busy [*8]) else $error("busy low in program");
  a_prog_wel: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE4]
    (st_q == S_PROG && tmr_q == '0 && !wel_set) |=> !busy && !write_latch_flag)
    else $error("write latch not cleared");
  a_prot_skip: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE5]
    (st_q == S_IDLE && pend_q && cs_s_q && xop_q && prot) |=> st_q == S_IDLE && !busy)
    else $error("protected page programmed");
  a_ecc_limit: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE2]
    aw |-> (!ecc_enable || int'(idx_q) < USER_BYTES)) else $error("ecc area programmed");
  a_fetch_full: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE9]
    (st_q == S_FETCH && tmr_q == '0) |-> int'(idx_q) == BUF_BYTES)
    else $error("busy cleared before buffer loaded");
  a_start_cs: assert property (@(posedge core_clk) disable iff (!rst_b) // [RULE1]
    $rose(busy) |-> $past(cs_s_q) && $past(pend_q)) else $error("cycle started early");
  a_busy_ignore: assert property (@(posedge sck) disable iff (cs_b) // [RULE10]
    (cnt_q == OPC_LAST && bsy_s_q) |=> op_q == OP_NONE) else $error("command taken busy");
  a_dual_lines: assert property (@(negedge sck) disable iff (cs_b) // [RULE19]
    (dual && !data_line_one_oe_b) |-> !data_line_zero_oe_b) else $error("dual line idle");
  a_msb_first: assert property (@(negedge sck) disable iff (cs_b) // [RULE15]
    (don_q && !dual && obit_q != 3'h0) |=> data_line_one_out === $past(osh_q[7]))
    else $error("bit order wrong");
  a_buf_hiz: assert property (@(negedge sck) disable iff (cs_b) // [RULE17]
    (don_q && bm_s_q && stt_q && int'(pcol_q) >= BUF_BYTES && obit_q == 3'h0)
    |=> data_line_one_oe_b [*2]) else $error("driven past buffer end");
  c_prog: cover property (@(posedge core_clk) $rose(st_q == S_PROG));
  c_fetch: cover property (@(posedge core_clk) $rose(st_q == S_FETCH));
  c_dual: cover property (@(negedge sck) don_q && dual && !data_line_zero_oe_b);
  c_wrap: cover property (@(negedge sck) $rose(far_q));
endmodule
`default_nettype wire

// file: nsq_pkg.sv
`default_nettype none
package nsq_pkg;
  // opcodes
  localparam logic [7:0] OP_PROG = 8'h10;
  localparam logic [7:0] OP_FETCH = 8'h13;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_NONE = 8'h00;
  // buffer geometry
  localparam int BUF_BYTES = 2112;
  localparam int USER_BYTES = 2048;
  localparam int COL_W = 12;
  localparam int PAGE_W = 16;
  // bit counts from the start of a frame
  localparam logic [6:0] OPC_LAST = 7'h07;
  localparam logic [6:0] COL_LAST = 7'h17;
  localparam logic [6:0] HDR_LAST = 7'h1F;
  localparam logic [6:0] END_READ = 7'h20;
  localparam logic [6:0] END_FAST_BUF = 7'h20;
  localparam logic [6:0] END_FAST_CONT = 7'h28;
  localparam logic [6:0] END_FAST4_BUF = 7'h30;
  localparam logic [6:0] END_FAST4_CONT = 7'h40;
  localparam logic [6:0] CNT_MAX = 7'h7F;
  // timing
  localparam int CLK_NS = 100;
  localparam int PROG_US = 700;
  localparam int FETCH_US = 250;
  localparam int PROG_CYC = (PROG_US * 1000) / CLK_NS;
  localparam int FETCH_CYC = (FETCH_US * 1000) / CLK_NS;
  localparam int TMR_W = 20;
  typedef enum logic [1:0] {S_IDLE, S_PROG, S_FETCH} core_state_t;
endpackage
`default_nettype wire

// file: spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  // link
  output logic sck,
  output logic cs_b,
  output logic mosi,
  // device line enables
  input wire logic d1_oe_b,
  input wire logic d0_oe_b
);
  logic [127:0] oe1_v;
  logic [127:0] oe0_v;
  logic last_oe;
  initial begin
    sck = 1'b0;
    cs_b <= 1'b1;
    mosi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // header msb first, then read clocks; idle mosi inverted
  task automatic xfer(input logic [63:0] hdr, input int nhdr, input int ntot);
    #37 cs_b = 1'b0;
    for (int i = 0; i < ntot; i++) begin
      mosi = (i < nhdr) ? hdr[63-i] : ~mosi;
      #80;
      if (i < 128) begin
        oe1_v[i] = d1_oe_b;
        oe0_v[i] = d0_oe_b;
      end
      last_oe = d1_oe_b;
      sck = 1'b1;
      #80 sck = 1'b0;
    end
    #80 cs_b = 1'b1;
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

// file: test_serial_nand_program_read.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_nand_program_read;
  import nsq_pkg::*;
  localparam int PROG_N = 2300;
  localparam int FETCH_N = 2200;
  logic core_clk, rst_b, buffer_mode, ecc_enable, top_bottom_select;
  logic protect_range_bit2, protect_range_bit1, protect_range_bit0, wel_set;
  logic write_latch_flag, busy, sck, cs_b, mosi;
  logic d0_out, d0_oe_b, d1_out, d1_oe_b;
  int n_fail = 0;
  int checks = 0;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  nand_seq #(.NUM_PAGES(64), .PROG_CYCLES(PROG_N), .FETCH_CYCLES(FETCH_N)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .buffer_mode(buffer_mode),
    .ecc_enable(ecc_enable), .top_bottom_select(top_bottom_select),
    .protect_range_bit2(protect_range_bit2), .protect_range_bit1(protect_range_bit1),
    .protect_range_bit0(protect_range_bit0), .wel_set(wel_set),
    .write_latch_flag(write_latch_flag), .busy(busy), .sck(sck), .cs_b(cs_b),
    .data_line_zero_in(mosi), .data_line_zero_out(d0_out), .data_line_zero_oe_b(d0_oe_b),
    .data_line_one_in(1'b0), .data_line_one_out(d1_out), .data_line_one_oe_b(d1_oe_b));
  spi_host u_host (.sck(sck), .cs_b(cs_b), .mosi(mosi), .d1_oe_b(d1_oe_b), .d0_oe_b(d0_oe_b));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // wait for busy, then count its length in core cycles
  task automatic busy_len(output int len);
    int w;
    w = 0;
    len = 0;
    while (busy !== 1'b1) begin
      @(negedge core_clk);
      w++;
      if (w > 50) begin
        chk("busy_start", 1, 0);
        final_report();
      end
    end
    while (busy === 1'b1 && len < 9000) begin
      len++;
      @(negedge core_clk);
    end
    if (busy === 1'b1) begin
      chk("busy_end", 0, 1);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_fetch(input logic [15:0] page);
    int len;
    u_host.xfer({OP_FETCH, 8'h00, page, 32'h0}, 32, 32);
    busy_len(len);
    chk("fetch_busy", FETCH_N, len);
  endtask
  task automatic t_prog(input logic [15:0] page, input logic ecc);
    int len;
    @(posedge core_clk);
    ecc_enable <= ecc;
    wel_set <= 1'b1;
    @(posedge core_clk);
    wel_set <= 1'b0;
    @(negedge core_clk);
    chk("latch_set", 1, write_latch_flag);
    u_host.xfer({OP_PROG, 8'h00, page, 32'h0}, 32, 32);
    busy_len(len);
    chk("prog_busy", PROG_N, len);
    chk("latch_clear", 0, write_latch_flag);
  endtask
  task automatic t_protect();
    @(posedge core_clk);
    protect_range_bit0 <= 1'b1;
    top_bottom_select <= 1'b1;
    wel_set <= 1'b1;
    @(posedge core_clk);
    wel_set <= 1'b0;
    u_host.xfer({OP_PROG, 8'h00, 16'h0000, 32'h0}, 32, 32);
    repeat (20) @(negedge core_clk);
    chk("prot_busy", 0, busy);
    chk("prot_latch", 1, write_latch_flag);
  endtask
  // n header bits, then nrd read clocks; xl = line enable at the last clock
  task automatic t_read(input logic [7:0] op, input logic bm, input int n,
                        input logic [15:0] col, input int nrd, input logic xl);
    @(posedge core_clk);
    buffer_mode <= bm;
    repeat (4) @(posedge core_clk);
    u_host.xfer({op, col, 40'h0}, n, n + nrd);
    @(negedge core_clk);
    chk("oe_before", 1, u_host.oe1_v[n-1]);
    chk("oe_first", 0, u_host.oe1_v[n]);
    chk("oe_dual", (op == OP_DUAL) ? 0 : 1, u_host.oe0_v[n]);
    chk("oe_last", xl, u_host.last_oe);
    chk("oe_cs_high", 1, d1_oe_b);
    chk("oe0_cs_high", 1, d0_oe_b);
    chk("out1_idle", 0, d1_out);
    chk("out0_idle", 0, d0_out);
  endtask
  task automatic t_refuse();
    int len;
    u_host.xfer({OP_FETCH, 8'h00, 16'h0002, 32'h0}, 32, 32);
    repeat (10) @(negedge core_clk);
    u_host.xfer({OP_READ, 40'h0, 16'h0}, 32, 48);
    chk("busy_read", 1, u_host.oe1_v[32]);
    busy_len(len);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_b <= 1'b0;
    buffer_mode = 1'b1;
    ecc_enable = 1'b0;
    top_bottom_select = 1'b0;
    protect_range_bit2 = 1'b0;
    protect_range_bit1 = 1'b0;
    protect_range_bit0 = 1'b0;
    wel_set = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk("rst_busy", 0, busy);
    chk("rst_latch", 0, write_latch_flag);
    t_fetch(16'h0005);
    for (int m = 0; m < 2; m++) begin
      t_read(OP_READ, m[0], 32, 16'h0000, 16, 1'b0);
      t_read(OP_FAST, m[0], m[0] ? 32 : 40, 16'h0010, 16, 1'b0);
      t_read(OP_FAST4, m[0], m[0] ? 48 : 64, 16'h0010, 16, 1'b0);
      t_read(OP_DUAL, m[0], m[0] ? 32 : 40, 16'h0010, 16, 1'b0);
    end
    t_read(OP_READ, 1'b1, 32, 16'h083F, 16, 1'b1);
    t_read(OP_DUAL, 1'b0, 40, 16'h0000, 2112 * 4 + 8, 1'b0);
    t_refuse();
    t_protect();
    t_prog(16'h0001, 1'b0);
    @(posedge core_clk);
    protect_range_bit0 <= 1'b0;
    t_prog(16'h0003, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
